// ### design/sdc_control.sv
// Summary of operation
// RULE1: First divider bits 11-9: 1,3,16,48; 1xx reserved
// RULE2: Second divider bits 7-6: 1,2,4,8
// RULE3: Both dividers cascade; ratios multiply
// RULE4: Bits 5-4 pick main, sub, aux, timer
// RULE5: Bit 8 selects reduced-power slower mode
// RULE6: Bit 3 switches mid-rail buffer
// RULE7: Bit 2 switches reference generator
// RULE8: Overflow irq needs bit 1 and global enable
// RULE9: Bits 15-12 and 0 read zero
// RULE10: Register at 0100h, cleared on reset
// RULE11: Overflow flags cleared only by software
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "sdc_params.svh"

module sdc_control
  import sdc_pkg::*;
#(
  parameter int CHANNELS = 7
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire sdc_req_t req,
  output logic [15:0] rdata,
  input wire logic main_clk_en,
  input wire logic sub_main_clk_en,
  input wire logic aux_clk_en,
  input wire logic timer_external_clock,
  input wire logic global_irq_enable,
  input wire logic [CHANNELS-1:0] overflow_set,
  input wire logic [CHANNELS-1:0] overflow_clear,
  output logic [CHANNELS-1:0] overflow_flag,
  output logic modulator_clk_en,
  output logic reduced_power_select,
  output logic midrail_buffer_on,
  output logic reference_generator_on,
  output logic overflow_irq
);

  // ****************************************
  // Register access
  // ****************************************

  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic [15:0] rdata_nxt;
  logic timer_prev_r;
  sdc_ctl_t ctl;

  // Control register decode is a single address match
  wire hit = (req.addr == `SDC_CTL_ADDR);
  wire ctl_wr = req.wr & hit;
  // Read strobe qualified the same way as the write
  wire ctl_rd = req.rd & hit;

  // RULE9: reserved bits masked
  // Masking on the way in keeps the reserved flops at zero,
  // so every reader of ctl_r sees them cleared
  assign ctl_nxt = ctl_wr ? (req.wdata & `SDC_CTL_WMASK) : ctl_r;
  // RULE9: unmapped reads return zero
  assign rdata_nxt = ctl_rd ? ctl_r : 16'h0000;

  // RULE10: cleared by reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= `SDC_CTL_RESET;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // Read data stands one cycle; idle cycles return zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // Field view of the register
  assign ctl = '{first_stage_divider: ctl_r[`SDC_XDIV_MSB:`SDC_XDIV_LSB],
                 reduced_power_select: ctl_r[`SDC_LP_BIT],
                 second_stage_divider: ctl_r[`SDC_DIV_MSB:`SDC_DIV_LSB],
                 clock_source_select: sdc_src_t'(ctl_r[`SDC_SSEL_MSB:`SDC_SSEL_LSB]),
                 midrail_buffer_on: ctl_r[`SDC_VMID_BIT],
                 reference_generator_on: ctl_r[`SDC_REF_BIT],
                 overflow_irq_enable: ctl_r[`SDC_OVIE_BIT]};

  // ****************************************
  // Clock source and dividers
  // ****************************************

  // First stage ratio; reserved codes treated as divide by 1
  function automatic logic [7:0] first_ratio(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h01;
    if (!code[2]) begin
      unique case (code[1:0])
        2'h0: r = `SDC_XDIV_R0;
        2'h1: r = `SDC_XDIV_R1;
        2'h2: r = `SDC_XDIV_R2;
        2'h3: r = `SDC_XDIV_R3;
      endcase
    end
    return r;
  endfunction

  // Timer clock is sampled; a rising edge gives one source tick
  wire timer_tick = timer_external_clock & ~timer_prev_r;

  // RULE4: source select
  wire src_tick = (ctl.clock_source_select == SDC_SRC_MAIN) ? main_clk_en :
                  (ctl.clock_source_select == SDC_SRC_SUB) ? sub_main_clk_en :
                  (ctl.clock_source_select == SDC_SRC_AUX) ? aux_clk_en : timer_tick;

  // RULE1: first stage terminal count
  wire [7:0] x_ratio = first_ratio(ctl.first_stage_divider);
  // RULE2: second stage ratio is a power of two
  wire [3:0] d_ratio = 4'h1 << ctl.second_stage_divider;

  logic [7:0] xcnt_r;
  logic [7:0] xcnt_nxt;
  logic [3:0] dcnt_r;
  logic [3:0] dcnt_nxt;
  logic mod_en_r;
  logic [CHANNELS-1:0] ovf_r;
  logic irq_r;

  // Terminal test shared by both stages; the short one is zero extended
  function automatic logic at_terminal(input logic [7:0] count, input logic [7:0] ratio);
    return count >= ratio - 8'h01;
  endfunction

  wire x_wrap = src_tick & at_terminal(xcnt_r, x_ratio);
  // RULE3: second stage counts first stage outputs
  wire d_wrap = x_wrap & at_terminal({4'h0, dcnt_r}, {4'h0, d_ratio});

  // Counters restart on any control register write so a new ratio takes effect cleanly;
  // the price is one lengthened period spanning each write, as the partial count is dropped
  assign xcnt_nxt = (ctl_wr | x_wrap) ? 8'h00 :
                    src_tick ? xcnt_r + 8'h01 : xcnt_r;
  assign dcnt_nxt = (ctl_wr | d_wrap) ? 4'h0 :
                    x_wrap ? dcnt_r + 4'h1 : dcnt_r;

  // Timer pin history for the edge detector; a pin that idles high
  // gives one early tick after reset, never counted since the reset value selects the main source
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timer_prev_r <= 1'b0;
    end else begin
      timer_prev_r <= timer_external_clock;
    end
  end

  // First stage count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xcnt_r <= 8'h00;
    end else begin
      xcnt_r <= xcnt_nxt;
    end
  end

  // Second stage count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dcnt_r <= 4'h0;
    end else begin
      dcnt_r <= dcnt_nxt;
    end
  end

  // A write suppresses the pulse so an old ratio never leaks a tick
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mod_en_r <= 1'b0;
    end else begin
      mod_en_r <= d_wrap & ~ctl_wr;
    end
  end

  // ****************************************
  // Overflow flags and interrupt
  // ****************************************

  // RULE11: set wins, clear only by software
  wire [CHANNELS-1:0] ovf_nxt = overflow_set | (ovf_r & ~overflow_clear);
  // RULE8: both enables gate the request
  wire irq_nxt = (|ovf_nxt) & ctl.overflow_irq_enable & global_irq_enable;

  // Sticky per-channel flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ovf_r <= '0;
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  // Request follows the next flag state so it rises with the flag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign overflow_flag = ovf_r;
  assign overflow_irq = irq_r;
  assign modulator_clk_en = mod_en_r;
  // RULE5: reduced power mode
  assign reduced_power_select = ctl_r[`SDC_LP_BIT];
  // RULE6: mid-rail buffer
  assign midrail_buffer_on = ctl_r[`SDC_VMID_BIT];
  // RULE7: reference generator
  assign reference_generator_on = ctl_r[`SDC_REF_BIT];

endmodule // sdc_control

// ### design/sdc_params.svh
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// Register address of the control register
`define SDC_CTL_ADDR 16'h0100
// Field positions
`define SDC_XDIV_MSB 11
`define SDC_XDIV_LSB 9
`define SDC_LP_BIT 8
`define SDC_DIV_MSB 7
`define SDC_DIV_LSB 6
`define SDC_SSEL_MSB 5
`define SDC_SSEL_LSB 4
`define SDC_VMID_BIT 3
`define SDC_REF_BIT 2
`define SDC_OVIE_BIT 1
// Writable bits and reset value
`define SDC_CTL_WMASK 16'h0FFE
`define SDC_CTL_RESET 16'h0000
// Divider ratios
`define SDC_XDIV_R0 8'h01
`define SDC_XDIV_R1 8'h03
`define SDC_XDIV_R2 8'h10
`define SDC_XDIV_R3 8'h30

`endif

// ### design/sdc_pkg.sv
package sdc_pkg;

  // Clock source choices
  typedef enum logic [1:0] {
    SDC_SRC_MAIN = 2'h0,
    SDC_SRC_SUB = 2'h1,
    SDC_SRC_AUX = 2'h2,
    SDC_SRC_TIMER = 2'h3
  } sdc_src_t;

  // Decoded control fields
  typedef struct packed {
    logic [2:0] first_stage_divider;
    logic reduced_power_select;
    logic [1:0] second_stage_divider;
    sdc_src_t clock_source_select;
    logic midrail_buffer_on;
    logic reference_generator_on;
    logic overflow_irq_enable;
  } sdc_ctl_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sdc_req_t;

endpackage

// ### verification/sdc_control_assertions.sv
`timescale 1ns/1ps
module sdc_control_assertions import sdc_pkg::*; #(parameter int CHANNELS = 7) (
  input wire logic clock,
  input wire logic rst_b,
  input wire sdc_req_t req,
  input wire logic [15:0] rdata,
  input wire logic global_irq_enable,
  input wire logic [CHANNELS-1:0] overflow_set,
  input wire logic [CHANNELS-1:0] overflow_clear,
  input wire logic [CHANNELS-1:0] overflow_flag,
  input wire logic modulator_clk_en,
  input wire logic reduced_power_select,
  input wire logic midrail_buffer_on,
  input wire logic reference_generator_on,
  input wire logic overflow_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Accepted control write
  wire ctl_wr = req.wr && req.addr == 16'h0100;
  chk_lp_write: assert property (ctl_wr |=> reduced_power_select == $past(req.wdata[8]))
    else $error("reduced power level wrong");
  chk_mid_write: assert property (ctl_wr |=> midrail_buffer_on == $past(req.wdata[3]))
    else $error("midrail level wrong");
  chk_ref_write: assert property (ctl_wr |=> reference_generator_on == $past(req.wdata[2]))
    else $error("reference level wrong");
  chk_read_reserved: assert property (req.rd |=> rdata[15:12] == 4'h0 && !rdata[0])
    else $error("reserved bits read nonzero");
  chk_read_unmapped: assert property (req.rd && req.addr != 16'h0100 |=> rdata == 16'h0000)
    else $error("unmapped read nonzero");
  chk_irq_gate: assert property (overflow_irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  chk_flag_keep: assert property (1 |=> (overflow_flag & $past(overflow_flag & ~overflow_clear))
    == $past(overflow_flag & ~overflow_clear))
    else $error("flag lost without clear");
  chk_flag_set: assert property (|overflow_set |=>
    (overflow_flag & $past(overflow_set)) == $past(overflow_set))
    else $error("flag not set");
  // Main scenarios reached
  cover property (ctl_wr);
  cover property (overflow_irq);
  cover property (modulator_clk_en);
endmodule // sdc_control_assertions
bind sdc_control sdc_control_assertions #(.CHANNELS(CHANNELS)) i_sdc_control_assertions (.clock(clock),
  .rst_b(rst_b), .req(req), .rdata(rdata), .global_irq_enable(global_irq_enable), .overflow_set(overflow_set),
  .overflow_clear(overflow_clear), .overflow_flag(overflow_flag), .modulator_clk_en(modulator_clk_en),
  .reduced_power_select(reduced_power_select), .midrail_buffer_on(midrail_buffer_on),
  .reference_generator_on(reference_generator_on), .overflow_irq(overflow_irq));

// ### verification/sdc_control_bench.sv
`timescale 1ns/1ps
module sdc_control_bench;
  import sdc_pkg::*;
  typedef struct {logic [15:0] d; int p;} sdc_row_t;
  logic clock = 0, rst_b = 0, m_en = 0, s_en = 0, a_en = 0, t_clk = 0, g = 0;
  logic [6:0] ov_set = 0, ov_clr = 0, flag;
  logic [15:0] rdata;
  logic [1:0] src;
  logic mod_en, lp, vmid, refon, irq;
  sdc_req_t req = '0;
  int errors = 0, num_checks = 0, n;
  // Control word and modulator pulses per 96 main ticks (other sources tick half as often)
  sdc_row_t rows[9] = '{'{16'h0000, 96}, '{16'h0240, 16}, '{16'h0400, 6}, '{16'h0600, 2}, '{16'h034E, 16},
    '{16'h00C0, 12}, '{16'hF831, 48}, '{16'h0010, 48}, '{16'h002C, 48}};
  sdc_control i_sdc_control (.clock(clock), .rst_b(rst_b), .req(req), .rdata(rdata), .main_clk_en(m_en),
    .sub_main_clk_en(s_en), .aux_clk_en(a_en), .timer_external_clock(t_clk), .global_irq_enable(g),
    .overflow_set(ov_set), .overflow_clear(ov_clr), .overflow_flag(flag), .modulator_clk_en(mod_en),
    .reduced_power_select(lp), .midrail_buffer_on(vmid), .reference_generator_on(refon), .overflow_irq(irq));
  initial forever #10 clock = ~clock;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bus cycles; an idle edge follows so no edge sees two drives of req
  task wr(input logic [15:0] ad, input logic [15:0] d);
    req <= '{1'b1, 1'b0, ad, d};
    @(posedge clock) req <= '0;
    @(posedge clock);
  endtask
  task rd(input logic [15:0] ad, input logic [15:0] exp);
    req <= '{1'b0, 1'b1, ad, 16'h0000};
    @(posedge clock) req <= '0;
    @(posedge clock) chk(rdata, exp);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    rd(16'h0100, 16'h0000);
    foreach (rows[i]) begin
      wr(16'h0100, rows[i].d);
      rd(16'h0100, rows[i].d & 16'h0FFE);
      chk(16'({lp, vmid, refon}), 16'({rows[i].d[8], rows[i].d[3:2]}));
      src = rows[i].d[5:4];
      n = 0;
      // Selected source ticks; counting runs a few cycles past the last tick
      for (int k = 0; k < 100; k++) begin
        m_en <= k < 96;
        s_en <= k < 96 && k[0] && src == 2'h1;
        a_en <= k < 96 && k[0] && src == 2'h2;
        t_clk <= k < 96 && !k[0] && src == 2'h3;
        @(posedge clock) n += mod_en;
      end
      chk(16'(n), 16'(rows[i].p));
    end
    wr(16'h0102, 16'h0FFE);
    rd(16'h0100, 16'h002C);
    rd(16'h0102, 16'h0000);
    wr(16'h0100, 16'h0002);
    g <= 1;
    ov_set <= 7'h01;
    @(posedge clock) ov_set <= 0;
    @(posedge clock) chk(16'(irq), 16'h0001);
    g <= 0;
    // The new enable level is sampled one edge later; the request drops after that edge
    repeat (2) @(posedge clock);
    chk(16'(irq), 16'h0000);
    rd(16'h0100, 16'h0002);
    chk(16'(flag), 16'h0001);
    ov_clr <= 7'h01;
    @(posedge clock) ov_clr <= 0;
    @(posedge clock) chk(16'(flag), 16'h0000);
    // Overflow enable off: a flag alone must not request; set beats a same-cycle clear
    wr(16'h0100, 16'h000C);
    g <= 1;
    ov_set <= 7'h02;
    ov_clr <= 7'h02;
    @(posedge clock) ov_set <= 0;
    ov_clr <= 0;
    @(posedge clock) chk(16'(flag), 16'h0002);
    chk(16'(irq), 16'h0000);
    // Mid-run reset must clear the register, the flags and the levels
    rst_b <= 0;
    repeat (2) @(posedge clock);
    chk(16'({flag, lp, vmid, refon, irq}), 16'h0000);
    rst_b <= 1;
    @(posedge clock) rd(16'h0100, 16'h0000);
    test_done;
  end
endmodule // sdc_control_bench
